// ---- bench/adcc_core_model.sv ----
// Behavioural model of the analog converter core that measures the phases it is given.
`timescale 1ns/1ps
module adcc_core_model (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        conv_tick,
  input  wire logic        ana_sample,
  input  wire logic        ana_convert,
  input  wire logic [2:0]  ana_channel,
  output logic      [31:0] sh_last,
  output logic      [31:0] cv_last,
  output logic      [31:0] tick_gap,
  output logic      [31:0] n_conv,
  output logic      [2:0]  last_ch
);
  logic [31:0] sh_run;
  logic [31:0] cv_run;
  logic [31:0] gap_cnt;
  logic        conv_d;
  logic [2:0]  ch_d;

  // A conversion is taken as finished when the convert phase falls.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {sh_run, cv_run, gap_cnt, sh_last, cv_last, tick_gap, n_conv} <= '0;
      conv_d  <= 1'b0;
      ch_d    <= 3'h0;
      last_ch <= 3'h0;
    end else begin
      conv_d  <= ana_convert;
      ch_d    <= ana_channel;
      gap_cnt <= gap_cnt + 1;
      if (conv_tick) begin
        tick_gap <= gap_cnt + 1;
        gap_cnt  <= '0;
      end
      if (ana_sample && conv_tick) sh_run <= sh_run + 1;
      if (ana_convert && conv_tick) cv_run <= cv_run + 1;
      if (conv_d && !ana_convert) begin
        sh_last <= sh_run;
        cv_last <= cv_run;
        sh_run  <= {31'h0, ana_sample && conv_tick};
        cv_run  <= '0;
        n_conv  <= n_conv + 1;
        last_ch <= ch_d;
      end
    end
  end
endmodule : adcc_core_model

// ---- bench/adcc_top_tb.sv ----
// Self-checking testbench of the converter control block.
`timescale 1ns/1ps
`include "adcc_defines.svh"
module adcc_top_tb;
  import adcc_pkg::*;
  logic        hclk = 1'b0;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hready;
  logic        hreadyout;
  logic [31:0] hrdata;
  logic        conv_tick, ana_sample, ana_convert, ana_ref_en, conv_irq, hresp, ana_idle_run;
  logic [2:0]  ana_channel, last_ch;
  logic [31:0] sh_last, cv_last, tick_gap, n_conv, n0, rd;
  int          num_errors = 0;
  int          n_checks = 0;
  int          cyc = 0;
  logic [3:0]  tsh_c [7] = '{4'h8, 4'h9, 4'hA, 4'hB, 4'h3, 4'hC, 4'hD};
  logic [31:0] sh_n  [7] = '{32'd8, 32'd16, 32'd24, 32'd32, 32'd64, 32'd128, 32'd512};
  logic [31:0] itm_n [3] = '{32'd1, 32'd4, 32'd8};

  always #20 hclk = ~hclk;
  assign hready = hreadyout;

  adcc_top adcc_top_inst (
    .hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .conv_tick(conv_tick),
    .ana_sample(ana_sample), .ana_convert(ana_convert), .ana_channel(ana_channel),
    .ana_ref_en(ana_ref_en), .ana_idle_run(ana_idle_run), .conv_irq(conv_irq)
  );

  adcc_core_model adcc_core_model_inst (
    .hclk(hclk), .hresetn(hresetn), .conv_tick(conv_tick), .ana_sample(ana_sample),
    .ana_convert(ana_convert), .ana_channel(ana_channel), .sh_last(sh_last),
    .cv_last(cv_last), .tick_gap(tick_gap), .n_conv(n_conv), .last_ch(last_ch)
  );

  task automatic end_of_test();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_of_test

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : check

  // One single-word transfer; each phase is held until hready is sampled high.
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel   <= 1'b1;
    haddr  <= {24'h000000, a};
    htrans <= 2'b10;
    hwrite <= wr;
    hsize  <= `ADCC_HSIZE_WORD;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask : ahb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    ahb(1'b1, a, d);
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    ahb(1'b0, a, 32'h00000000);
    check(rd, exp);
  endtask : rd_chk

  task automatic wait_irq();
    int i;
    for (i = 0; i < 4000 && conv_irq !== 1'b1; i++) @(posedge hclk);
    check({31'h0, conv_irq}, 32'h1);
    repeat (2) @(posedge hclk);
  endtask : wait_irq

  task automatic run(input logic [7:0] cfg, input logic [7:0] m);
    wr(`ADCC_OFF_CLK, {24'h0, cfg});
    wr(`ADCC_OFF_MOD0, {24'h0, m});
    wr(`ADCC_OFF_MOD0, {24'h0, m | 8'h01});
    wait_irq();
  endtask : run

  task automatic wait_idle();
    int i;
    rd = 32'h40;
    for (i = 0; i < 400 && rd[6] !== 1'b0; i++) ahb(1'b0, `ADCC_OFF_MOD0, 32'h0);
    check({31'h0, rd[6]}, 32'h0);
  endtask : wait_idle

  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      num_errors++;
      end_of_test();
    end
  end

  initial begin
    {hsel, haddr, htrans, hwrite, hsize, hwdata} = '0;
    hresetn = 1'b0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    rd_chk(`ADCC_OFF_TRIM, 32'h38);
    rd_chk(`ADCC_OFF_CLK, 32'h80);
    rd_chk(`ADCC_OFF_MOD0, 32'h00);
    wr(`ADCC_OFF_TRIM, 32'h00000058);
    rd_chk(`ADCC_OFF_TRIM, 32'h58);
    wr(`ADCC_OFF_CLK, 32'hFFFFFFFF);
    rd_chk(`ADCC_OFF_CLK, 32'hF7);
    wr(`ADCC_OFF_MOD1, 32'hFFFFFFFF);
    rd_chk(`ADCC_OFF_MOD1, 32'hEF);
    check({31'h0, ana_idle_run}, 32'h1);
    wr(8'h24, 32'hFFFFFFFF);
    rd_chk(8'h24, 32'h00);
    check({31'h0, hresp}, 32'h0);
    wr(`ADCC_OFF_MOD1, 32'h00000083);
    repeat (75) @(posedge hclk);
    check({31'h0, ana_ref_en}, 32'h1);
    wr(`ADCC_OFF_CLK, 32'h00000081);
    wr(`ADCC_OFF_MOD0, 32'h00000000);
    wr(`ADCC_OFF_MOD0, 32'h00000001);
    @(posedge hclk);
    rd_chk(`ADCC_OFF_MOD0, 32'h40);
    wait_irq();
    check({29'h0, last_ch}, 32'h3);
    rd_chk(`ADCC_OFF_MOD0, 32'h80);
    rd_chk(`ADCC_OFF_MOD0, 32'h00);
    for (int i = 0; i < 7; i++) begin
      run({tsh_c[i], 4'h0}, 8'h00);
      check(sh_last, sh_n[i]);
      check(sh_last + cv_last, sh_n[i] + `ADCC_CONV_CLKS);
    end
    for (int d = 0; d < 5; d++) begin
      run({5'b10000, d[2:0]}, 8'h00);
      check(tick_gap, 32'h1 << d);
    end
    wr(`ADCC_OFF_MOD1, 32'h00000086);
    n0 = n_conv;
    run(8'h80, 8'h02);
    check(n_conv - n0, 32'd3);
    check({29'h0, last_ch}, 32'h6);
    wr(`ADCC_OFF_MOD1, 32'h00000083);
    for (int k = 0; k < 3; k++) begin
      run(8'h80, {3'h0, k[1:0], 3'b100});
      n0 = n_conv;
      wait_irq();
      check(n_conv - n0, itm_n[k]);
      wr(`ADCC_OFF_MOD0, {27'h0, k[1:0], 3'b000});
      wait_idle();
    end
    wr(`ADCC_OFF_MOD1, 32'h00000086);
    run(8'h80, 8'h16);
    n0 = n_conv;
    wait_irq();
    check(n_conv - n0, 32'd3);
    wr(`ADCC_OFF_MOD0, 32'h00000012);
    wait_idle();
    end_of_test();
  end
endmodule : adcc_top_tb

// ---- hw/adcc_clkdiv.sv ----
// Conversion clock divider producing one tick per conversion clock.
`timescale 1ns/1ps
module adcc_clkdiv
  import adcc_pkg::*;
(
  input  logic    hclk,
  input  logic    hresetn,
  input  logic    ce,
  adcc_clk_if.gen cif
);

  adcc_div_t  q;
  adcc_div_t  d;
  logic [3:0] mask;

  always_comb begin
    case (cif.div_sel)
      3'h0:    mask = 4'h0;
      3'h1:    mask = 4'h1;
      3'h2:    mask = 4'h3;
      3'h3:    mask = 4'h7;
      default: mask = 4'hF;
    endcase
  end

  // The count restarts with each run so the first tick is a fixed distance away.
  assign cif.tick = cif.run && ((q.cnt & mask) == mask); // R3

  always_comb begin
    d = q;
    d.cnt = cif.run ? q.cnt + 4'h1 : 4'h0;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '0;
    end else if (ce) begin
      q <= d;
    end
  end

  property p_div_full;
    @(posedge hclk) disable iff (!hresetn)
      (cif.run && cif.div_sel == 3'h0) |-> cif.tick;
  endproperty
  a_div_full: assert property (p_div_full) else $error("undivided clock missed a tick"); // R3

  property p_div_half;
    @(posedge hclk) disable iff (!hresetn)
      (ce && cif.run && cif.div_sel == 3'h1 && cif.tick) ##1 (ce && cif.run) |-> !cif.tick ##1 cif.tick;
  endproperty
  a_div_half: assert property (p_div_half) else $error("half rate ticks out of step"); // R3

endmodule : adcc_clkdiv

// ---- hw/adcc_top.sv ----
// Converter clock, sample-hold and mode control with its register slave.
//
// Implementation choices: the AHB-Lite register port and the address map.
`timescale 1ns/1ps
`include "adcc_defines.svh"
// Overview of operation
// R1 - Software writes the accuracy trim field to 0x58 before using the converter.
// R2 - Sample-hold lasts 8,16,24,32,64,128 or 512 conversion clocks per code.
// R3 - Conversion clock is the gear clock divided by 1,2,4,8 or 16.
// R4 - One conversion spans at least 46 conversion clocks including sample-hold.
// R5 - Software leaves the divider alone while a conversion runs.
// R6 - Software keeps the conversion clock at or below 40MHz.
// R7 - Done flag, bit 7, reads 1 after completion, 0 before or during.
// R8 - Reading the mode register clears the done flag.
// R9 - Busy flag, bit 6, reads 1 while a conversion runs.
// R10 - Interval field raises the interrupt every 1, 4 or 8 conversions.
// R11 - Interval field acts only in fixed-channel repeat mode.
// R12 - Bit 2 selects single conversion or continuous repeat.
// R13 - Bit 1 selects one fixed channel or a scanned channel range.
// R14 - Writing 1 to bit 0 starts a conversion; bit 0 reads 0.
// R15 - Software sets the mode before writing the start trigger.
// R16 - For DMA use: converter reset, DMA request-wait, then converter setup.
// R17 - Software enables the reference, waits 3us, then starts.
// R18 - Channel select picks the fixed channel or the last scanned one.
// R19 - Reserved bits read zero and ignore writes.
// R20 - Single and scan modes interrupt and set done when the sequence ends.
module adcc_top
  import adcc_pkg::*;
#(
  parameter int CONV_CLKS = `ADCC_CONV_CLKS
) (
  input  logic        hclk,
  input  logic        hresetn,
  input  logic        ce,
  input  logic        hsel,
  input  logic [31:0] haddr,
  input  logic [1:0]  htrans,
  input  logic        hwrite,
  input  logic [2:0]  hsize,
  input  logic [31:0] hwdata,
  input  logic        hready,
  output logic        hreadyout,
  output logic [31:0] hrdata,
  output logic        hresp,
  output logic        conv_tick,
  output logic        ana_sample,
  output logic        ana_convert,
  output logic [2:0]  ana_channel,
  output logic        ana_ref_en,
  output logic        ana_idle_run,
  output logic        conv_irq
);

  localparam logic [`ADCC_CNT_W-1:0] CONV_LAST = `ADCC_CNT_W'(CONV_CLKS - 1);

  if (CONV_CLKS + 8 < `ADCC_MIN_TOTAL || CONV_CLKS > 511) begin : g_bad_conv
    $error("CONV_CLKS cannot meet the conversion length or counter width");
  end

  adcc_core_t q;
  adcc_core_t d;
  adcc_clk_if cif ();

  logic       xfer;
  logic       rd_mod0;
  logic       start_go;
  logic       conv_end;
  logic       done_set;
  logic       last_ch;
  logic [2:0] first_ch;
  logic [2:0] itv_last;

  function automatic logic [`ADCC_CNT_W-1:0] sh_clks(input logic [3:0] code);
    case (code)
      4'h8:    sh_clks = `ADCC_SH_8;
      4'h9:    sh_clks = `ADCC_SH_16;
      4'hA:    sh_clks = `ADCC_SH_24;
      4'hB:    sh_clks = `ADCC_SH_32;
      4'h3:    sh_clks = `ADCC_SH_64;
      4'hC:    sh_clks = `ADCC_SH_128;
      default: sh_clks = `ADCC_SH_512;
    endcase
  endfunction : sh_clks

  function automatic logic [31:0] rd_mux(input adcc_core_t s, input logic [7:0] a);
    rd_mux = 32'h0000_0000; // R19
    case (a)
      `ADCC_OFF_CLK: begin
        rd_mux[`ADCC_TSH_LSB +: 4] = s.tsh;
        rd_mux[`ADCC_DIV_LSB +: 3] = s.div;
      end
      `ADCC_OFF_MOD0: begin
        rd_mux[`ADCC_DONE_BIT]     = s.done; // R7
        rd_mux[`ADCC_BUSY_BIT]     = s.busy; // R9
        rd_mux[`ADCC_ITM_LSB +: 2] = s.itm;
        rd_mux[`ADCC_RPT_BIT]      = s.rpt;
        rd_mux[`ADCC_SCAN_BIT]     = s.scan;
      end
      `ADCC_OFF_MOD1: begin
        rd_mux[`ADCC_REF_BIT]       = s.ref_en;
        rd_mux[`ADCC_IDLE_BIT]      = s.idle_run;
        rd_mux[`ADCC_SCAN8_BIT]     = s.scan8;
        rd_mux[`ADCC_CHAN_LSB +: 4] = s.chan;
      end
      `ADCC_OFF_TRIM: rd_mux[7:0] = s.trim;
      default: rd_mux = 32'h0000_0000;
    endcase
  endfunction : rd_mux

  assign xfer    = hsel && hready && htrans[1];
  assign rd_mod0 = xfer && !hwrite && haddr[7:0] == `ADCC_OFF_MOD0 && haddr[31:8] == 24'h0;

  // A fixed channel repeats itself; a scan restarts at 0, or at 4 for a short high scan.
  assign first_ch = !q.scan ? q.chan[2:0] : q.scan8 ? 3'h0 : {q.chan[2], 2'b00}; // R18
  assign last_ch  = !q.scan || q.cur_ch == q.chan[2:0]; // R13

  always_comb begin
    case (q.itm)
      2'b01:   itv_last = 3'h3;
      2'b10:   itv_last = 3'h7;
      default: itv_last = 3'h0;
    endcase
  end

  always_comb begin
    d        = q;
    d.irq    = 1'b0;
    start_go = 1'b0;
    conv_end = 1'b0;
    done_set = 1'b0;
    if (q.wr_pend) begin
      d.wr_pend = 1'b0;
      case (q.wr_addr)
        `ADCC_OFF_CLK: begin
          d.tsh = hwdata[`ADCC_TSH_LSB +: 4];
          d.div = hwdata[`ADCC_DIV_LSB +: 3];
        end
        `ADCC_OFF_MOD0: begin
          d.itm    = hwdata[`ADCC_ITM_LSB +: 2];
          d.rpt    = hwdata[`ADCC_RPT_BIT];
          d.scan   = hwdata[`ADCC_SCAN_BIT];
          start_go = hwdata[`ADCC_START_BIT] && !q.busy; // R14
        end
        `ADCC_OFF_MOD1: begin
          d.ref_en   = hwdata[`ADCC_REF_BIT];
          d.idle_run = hwdata[`ADCC_IDLE_BIT];
          d.scan8    = hwdata[`ADCC_SCAN8_BIT];
          d.chan     = hwdata[`ADCC_CHAN_LSB +: 4];
        end
        `ADCC_OFF_TRIM: d.trim = hwdata[7:0];
        default: d.trim = q.trim;
      endcase
    end
    if (xfer && hwrite && hsize == `ADCC_HSIZE_WORD && haddr[31:8] == 24'h0) begin
      d.wr_pend = 1'b1;
      d.wr_addr = haddr[7:0];
    end
    // Reads see a write that completes at the same edge.
    if (xfer && !hwrite) begin
      d.rdata = haddr[31:8] == 24'h0 ? rd_mux(d, haddr[7:0]) : 32'h0000_0000;
    end
    if (rd_mod0) begin
      d.done = 1'b0; // R8
    end
    if (start_go) begin
      d.busy   = 1'b1; // R9
      d.done   = 1'b0; // R7
      d.seq    = ADCC_SAMPLE;
      d.cnt    = sh_clks(d.tsh) - `ADCC_CNT_W'(1); // R2
      d.cur_ch = !d.scan ? d.chan[2:0] : d.scan8 ? 3'h0 : {d.chan[2], 2'b00}; // R18
      d.conv_n = 3'h0;
    end else if (cif.tick) begin
      case (q.seq)
        ADCC_SAMPLE: begin
          if (q.cnt == '0) begin
            d.seq = ADCC_CONVERT;
            d.cnt = CONV_LAST; // R4
          end else begin
            d.cnt = q.cnt - `ADCC_CNT_W'(1);
          end
        end
        ADCC_CONVERT: begin
          if (q.cnt != '0) begin
            d.cnt = q.cnt - `ADCC_CNT_W'(1);
          end else begin
            conv_end = 1'b1;
            if (!q.scan && q.rpt) begin
              done_set = q.conv_n == itv_last; // R10 R11
              d.conv_n = done_set ? 3'h0 : q.conv_n + 3'h1;
            end else begin
              done_set = last_ch; // R20
            end
            if (q.rpt || !last_ch) begin
              d.seq    = ADCC_SAMPLE; // R12
              d.cnt    = sh_clks(q.tsh) - `ADCC_CNT_W'(1);
              d.cur_ch = last_ch ? first_ch : q.cur_ch + 3'h1; // R13
            end else begin
              d.seq  = ADCC_IDLE;
              d.busy = 1'b0;
            end
          end
        end
        default: begin
          d.seq  = ADCC_IDLE;
          d.busy = 1'b0;
        end
      endcase
    end
    // A completion in the same cycle as a clearing read keeps the flag set.
    if (done_set) begin
      d.done = 1'b1; // R7
      d.irq  = 1'b1; // R20
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q      <= '0;
      q.trim <= `ADCC_RST_TRIM; // R1
      q.tsh  <= `ADCC_RST_TSH;
      q.div  <= `ADCC_RST_DIV;
      q.seq  <= ADCC_IDLE;
    end else if (ce) begin
      q <= d;
    end
  end

  // The divider is read live, so it must stay put while busy.
  assign cif.div_sel = q.div; // R5
  assign cif.run     = q.busy;

  adcc_clkdiv u_div (
    .hclk    (hclk),
    .hresetn (hresetn),
    .ce      (ce),
    .cif     (cif.gen)
  );

  assign hreadyout    = ce;
  assign hresp        = 1'b0;
  assign hrdata       = q.rdata;
  assign conv_tick    = cif.tick;
  assign ana_sample   = q.seq == ADCC_SAMPLE;
  assign ana_convert  = q.seq == ADCC_CONVERT;
  assign ana_channel  = q.cur_ch;
  assign ana_ref_en   = q.ref_en;
  assign ana_idle_run = q.idle_run;
  assign conv_irq     = q.irq;

  sequence s_sample_end;
    ce && cif.tick && q.seq == ADCC_SAMPLE && q.cnt == '0;
  endsequence

  sequence s_convert_begin;
    q.seq == ADCC_CONVERT && q.cnt == CONV_LAST;
  endsequence

  property p_start_busy;
    @(posedge hclk) disable iff (!hresetn)
      (ce && start_go) |=> q.busy && !q.done && ana_sample && q.cnt == sh_clks(q.tsh) - 10'h001;
  endproperty
  a_start_busy: assert property (p_start_busy) else $error("start did not load sample-hold"); // R2

  property p_sample_to_convert;
    @(posedge hclk) disable iff (!hresetn)
      s_sample_end |=> s_convert_begin;
  endproperty
  a_sample_to_convert: assert property (p_sample_to_convert) else $error("convert phase short"); // R4

  property p_start_reads_zero;
    @(posedge hclk) disable iff (!hresetn)
      (ce && rd_mod0) |=> hrdata[`ADCC_START_BIT] == 1'b0 && hrdata[31:8] == 24'h0;
  endproperty
  a_start_reads_zero: assert property (p_start_reads_zero) else $error("start or upper bit read 1"); // R14

  property p_read_clears;
    @(posedge hclk) disable iff (!hresetn)
      (ce && rd_mod0 && !done_set) |=> !q.done;
  endproperty
  a_read_clears: assert property (p_read_clears) else $error("done survived a read"); // R8

  property p_set_wins;
    @(posedge hclk) disable iff (!hresetn)
      (ce && done_set) |=> q.done && conv_irq ##1 !conv_irq || !ce;
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("completion lost or irq too long"); // R20

  property p_busy_reads;
    @(posedge hclk) disable iff (!hresetn)
      (ce && rd_mod0) |=> hrdata[`ADCC_BUSY_BIT] == $past(q.busy);
  endproperty
  a_busy_reads: assert property (p_busy_reads) else $error("busy bit misreported"); // R9

  property p_interval4;
    @(posedge hclk) disable iff (!hresetn)
      (conv_end && q.rpt && !q.scan && q.itm == 2'b01) |-> done_set == (q.conv_n == 3'h3);
  endproperty
  a_interval4: assert property (p_interval4) else $error("interval of four missed"); // R10

  property p_single_ignores_itm;
    @(posedge hclk) disable iff (!hresetn)
      (conv_end && !q.rpt && !q.scan) |-> done_set;
  endproperty
  a_single_ignores_itm: assert property (p_single_ignores_itm) else $error("single end no done"); // R11

  property p_repeat_goes_on;
    @(posedge hclk) disable iff (!hresetn)
      (ce && conv_end && q.rpt) |=> q.busy && ana_sample;
  endproperty
  a_repeat_goes_on: assert property (p_repeat_goes_on) else $error("repeat stopped"); // R12

  property p_scan_steps;
    @(posedge hclk) disable iff (!hresetn)
      (ce && conv_end && q.scan && !last_ch) |=> ana_channel == $past(q.cur_ch) + 3'h1;
  endproperty
  a_scan_steps: assert property (p_scan_steps) else $error("scan did not advance"); // R13

endmodule : adcc_top

// ---- pkg/adcc_clk_if.sv ----
// Link between the control core and the conversion clock divider.
`timescale 1ns/1ps
interface adcc_clk_if;
  logic [2:0] div_sel;
  logic       run;
  logic       tick;
  modport ctl (output div_sel, output run, input tick);
  modport gen (input div_sel, input run, output tick);
endinterface : adcc_clk_if

// ---- pkg/adcc_defines.svh ----
// Register offsets, field positions, reset values and timing counts of the converter control.
`ifndef ADCC_DEFINES_SVH
`define ADCC_DEFINES_SVH

`define ADCC_ADDR_W      8
`define ADCC_OFF_CLK     8'h00
`define ADCC_OFF_MOD0    8'h04
`define ADCC_OFF_MOD1    8'h08
`define ADCC_OFF_TRIM    8'h20
`define ADCC_HSIZE_WORD  3'h2

`define ADCC_TSH_LSB     4
`define ADCC_DIV_LSB     0
`define ADCC_DONE_BIT    7
`define ADCC_BUSY_BIT    6
`define ADCC_ITM_LSB     3
`define ADCC_RPT_BIT     2
`define ADCC_SCAN_BIT    1
`define ADCC_START_BIT   0
`define ADCC_REF_BIT     7
`define ADCC_IDLE_BIT    6
`define ADCC_SCAN8_BIT   5
`define ADCC_CHAN_LSB    0

`define ADCC_RST_TRIM    8'h38
`define ADCC_RST_TSH     4'h8
`define ADCC_RST_DIV     3'h0

`define ADCC_CNT_W       10
`define ADCC_CONV_CLKS   38
`define ADCC_MIN_TOTAL   46
`define ADCC_SH_8        10'h008
`define ADCC_SH_16       10'h010
`define ADCC_SH_24       10'h018
`define ADCC_SH_32       10'h020
`define ADCC_SH_64       10'h040
`define ADCC_SH_128      10'h080
`define ADCC_SH_512      10'h200

`endif

// ---- pkg/adcc_pkg.sv ----
// Types shared by the converter control modules.
`include "adcc_defines.svh"
package adcc_pkg;

  typedef enum logic [1:0] {
    ADCC_IDLE    = 2'b00,
    ADCC_SAMPLE  = 2'b01,
    ADCC_CONVERT = 2'b10
  } adcc_seq_t;

  typedef struct packed {
    logic [7:0]             trim;
    logic [3:0]             tsh;
    logic [2:0]             div;
    logic [1:0]             itm;
    logic                   rpt;
    logic                   scan;
    logic                   ref_en;
    logic                   idle_run;
    logic                   scan8;
    logic [3:0]             chan;
    logic                   done;
    logic                   busy;
    adcc_seq_t              seq;
    logic [`ADCC_CNT_W-1:0] cnt;
    logic [2:0]             cur_ch;
    logic [2:0]             conv_n;
    logic                   irq;
    logic                   wr_pend;
    logic [`ADCC_ADDR_W-1:0] wr_addr;
    logic [31:0]            rdata;
  } adcc_core_t;

  typedef struct packed {
    logic [3:0] cnt;
  } adcc_div_t;

endpackage : adcc_pkg
